// ===== fault_monitor_pkg.sv
`default_nettype none
package fault_monitor_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    // ==========================================================
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_INCFG = 6'h04;
    localparam logic [5:0] OFF_PRIO = 6'h08;
    localparam logic [5:0] OFF_LOSCFG = 6'h0C;
    localparam logic [5:0] OFF_OOFCFG = 6'h10;
    localparam logic [5:0] OFF_LOLCFG = 6'h14;
    localparam logic [5:0] OFF_LOLTMR = 6'h18;
    localparam logic [5:0] OFF_LIVE = 6'h1C;
    localparam logic [5:0] OFF_STICKY = 6'h20;
    localparam logic [5:0] OFF_MASK = 6'h24;

    // ==========================================================
    // Field layouts
    // ==========================================================
    typedef struct packed {
        logic fast_en;
        logic precise_en;
        logic [2:0] oof_ref;
        logic shutdown_off;
        logic hitless;
        logic zero_delay;
        logic revertive;
        logic auto_mode;
        logic [1:0] reg_sel;
        logic sel_from_reg;
    } ctrl_s;

    typedef struct packed {
        logic hold;
        logic lock_loss_flag;
        logic [3:0] freq_out_of_range_flag;
        logic ref_los;
        logic [3:0] signal_loss_flag;
    } status_s;

    typedef enum logic [1:0] {
        ST_ACQ = 2'b00,
        ST_CLR_WAIT = 2'b01,
        ST_LOCKED = 2'b11
    } lock_st_e;

    // ==========================================================
    // Reset values and timing counts
    // ==========================================================
    localparam logic [12:0] CTRL_RST = 13'h1800;
    localparam logic [11:0] INCFG_RST = 12'hF0F;
    localparam logic [15:0] PRIO_RST = 16'h3210;
    localparam logic [23:0] LOSCFG_RST = 24'h402222;
    localparam logic [15:0] OOFCFG_RST = 16'h0103;
    localparam logic [31:0] LOLCFG_RST = 32'h0001000A;
    localparam logic [15:0] LOLTMR_RST = 16'h0010;
    localparam logic [10:0] MASK_RST = 11'h000;
    localparam int PRECISE_WIN_DEF = 1000000;
    localparam int FAST_WIN_DEF = 1000;
    localparam int FAST_PPM = 4000;
    localparam logic [15:0] REF_LOS_LIMIT = 16'h0040;

endpackage : fault_monitor_pkg
`default_nettype wire

// ===== input_select_fault_monitor.sv
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module input_select_fault_monitor
    import fault_monitor_pkg::*;
#(
    parameter int PRECISE_WIN = PRECISE_WIN_DEF,
    parameter int FAST_WIN = FAST_WIN_DEF
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Register port.
    input wire logic [5:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Sampled clock inputs, crystal and select pins.
    input wire logic [3:0] i_clk_in,
    input wire logic i_xtal_clk,
    input wire logic [1:0] i_in_sel_pins,
    // PLL side.
    input wire logic [15:0] i_pd_freq_diff,
    output logic [1:0] o_active_sel,
    output logic o_ref_valid,
    output logic o_holdover,
    output logic o_freerun,
    output logic o_hitless_en,
    output logic o_fastlock,
    output logic o_external_feedback_input,
    output logic o_outputs_enable,
    output logic [3:0] o_in_enable,
    output logic [3:0] o_in_differential,
    // Status pins.
    output logic o_lock_loss_flag,
    output logic o_status_interrupt_pin
);

    // ==========================================================
    // Registers and decode
    // ==========================================================
    localparam int FAST_LIM = FAST_PPM * FAST_WIN / 1000000;
    ctrl_s ctrl_r;
    logic [11:0] incfg_r;
    logic [15:0] prio_r;
    logic [23:0] loscfg_r;
    logic [15:0] oofcfg_r;
    logic [31:0] lolcfg_r;
    logic [15:0] loltmr_r;
    logic [10:0] sticky_r, mask_r;
    status_s live;
    wire wr_sticky = i_wr && (i_addr == OFF_STICKY);
    wire [10:0] clr_mask = wr_sticky ? i_wdata[10:0] : 11'h000;
    // Set wins over clear so no event slips through a clear write.
    wire [10:0] sticky_nxt = (sticky_r & ~clr_mask) | live;

    // Software-writable configuration; pins select by default.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ctrl_r <= ctrl_s'(CTRL_RST);
            incfg_r <= INCFG_RST;
            prio_r <= PRIO_RST;
            loscfg_r <= LOSCFG_RST;
            oofcfg_r <= OOFCFG_RST;
            lolcfg_r <= LOLCFG_RST;
            loltmr_r <= LOLTMR_RST;
            mask_r <= MASK_RST;
            sticky_r <= 11'h000;
        end else begin
            if (i_wr && i_addr == OFF_CTRL) ctrl_r <= ctrl_s'(i_wdata[12:0]);
            if (i_wr && i_addr == OFF_INCFG) incfg_r <= i_wdata[11:0];
            if (i_wr && i_addr == OFF_PRIO) prio_r <= i_wdata[15:0];
            if (i_wr && i_addr == OFF_LOSCFG) loscfg_r <= i_wdata[23:0];
            if (i_wr && i_addr == OFF_OOFCFG) oofcfg_r <= i_wdata[15:0];
            if (i_wr && i_addr == OFF_LOLCFG) lolcfg_r <= i_wdata;
            if (i_wr && i_addr == OFF_LOLTMR) loltmr_r <= i_wdata[15:0];
            if (i_wr && i_addr == OFF_MASK) mask_r <= i_wdata[10:0];
            sticky_r <= sticky_nxt;
        end
    end

    // ==========================================================
    // Edge detection and shared reference windows
    // ==========================================================
    logic [3:0] in_prev_r;
    logic xtal_prev_r;
    logic [20:0] prec_ref_r;
    logic [12:0] fast_ref_r;
    wire [3:0] in_edge = i_clk_in & ~in_prev_r;
    wire xtal_edge = i_xtal_clk & ~xtal_prev_r;
    // Any of the four inputs or the crystal can be the zero-ppm reference.
    wire ref_edge = (ctrl_r.oof_ref == 3'h0 || ctrl_r.oof_ref > 3'h4) ?
                    xtal_edge : in_edge[2'(ctrl_r.oof_ref - 3'h1)];
    wire prec_done = ref_edge && (prec_ref_r == 21'(PRECISE_WIN - 1));
    wire fast_done = ref_edge && (fast_ref_r == 13'(FAST_WIN - 1));

    // Window counters run on reference edges only.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            in_prev_r <= 4'h0;
            xtal_prev_r <= 1'b0;
            prec_ref_r <= 21'h000000;
            fast_ref_r <= 13'h0000;
        end else begin
            in_prev_r <= i_clk_in;
            xtal_prev_r <= i_xtal_clk;
            if (prec_done) prec_ref_r <= 21'h000000;
            else if (ref_edge) prec_ref_r <= prec_ref_r + 21'h000001;
            if (fast_done) fast_ref_r <= 13'h0000;
            else if (ref_edge) fast_ref_r <= fast_ref_r + 13'h0001;
        end
    end

    // ==========================================================
    // Per-input signal-loss and frequency monitors
    // ==========================================================
    logic [3:0] los_live, oof_live, valid;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_mon
            logic [15:0] per_r;
            logic [3:0] miss_r;
            logic [21:0] pcnt_r;
            logic [13:0] fcnt_r;
            logic oofp_r, ooff_r;
            // Tolerating a few missed periods lets gapped clocks pass.
            wire expired = per_r >= {8'h00, loscfg_r[23:16]};
            wire [3:0] sens = loscfg_r[4*g +: 4];
            wire [21:0] pdev = (pcnt_r >= 22'(PRECISE_WIN)) ?
                               pcnt_r - 22'(PRECISE_WIN) :
                               22'(PRECISE_WIN) - pcnt_r;
            wire [13:0] fdev = (fcnt_r >= 14'(FAST_WIN)) ?
                               fcnt_r - 14'(FAST_WIN) :
                               14'(FAST_WIN) - fcnt_r;
            // One count of the window is 1 ppm, so a 2 ppm step is two.
            wire [21:0] plim = {13'h0000, oofcfg_r[7:0], 1'b0};
            wire [21:0] phys = {14'h0000, oofcfg_r[15:8]};

            // Period timing and windowed edge counting.
            always_ff @(posedge i_ref_clk) begin
                if (i_sys_rst) begin
                    per_r <= 16'h0000;
                    miss_r <= 4'h0;
                    pcnt_r <= 22'h000000;
                    fcnt_r <= 14'h0000;
                    oofp_r <= 1'b0;
                    ooff_r <= 1'b0;
                end else begin
                    if (in_edge[g]) begin
                        per_r <= 16'h0000;
                        miss_r <= 4'h0;
                    end else if (expired) begin
                        per_r <= 16'h0000;
                        if (miss_r != 4'hF) miss_r <= miss_r + 4'h1;
                    end else begin
                        per_r <= per_r + 16'h0001;
                    end
                    if (prec_done) begin
                        pcnt_r <= {21'h000000, in_edge[g]};
                        if (pdev > plim) oofp_r <= 1'b1;
                        else if (pdev + phys <= plim) oofp_r <= 1'b0;
                    end else if (in_edge[g]) begin
                        pcnt_r <= pcnt_r + 22'h000001;
                    end
                    if (fast_done) begin
                        fcnt_r <= {13'h0000, in_edge[g]};
                        ooff_r <= fdev > 14'(FAST_LIM);
                    end else if (in_edge[g]) begin
                        fcnt_r <= fcnt_r + 14'h0001;
                    end
                end
            end
            assign los_live[g] = incfg_r[8+g] && (miss_r > sens);
            assign oof_live[g] = (oofp_r && ctrl_r.precise_en) ||
                                 (ooff_r && ctrl_r.fast_en);
            assign valid[g] = incfg_r[g] && !los_live[g] && !oof_live[g] &&
                              !(ctrl_r.zero_delay && g == 3);
        end
    endgenerate

    // ==========================================================
    // Input selection
    // ==========================================================
    // Lower priority value wins; strict compare keeps the lower input.
    function automatic logic [2:0] best_of(input logic [3:0] v,
                                           input logic [15:0] p);
        logic [2:0] res;
        logic [3:0] bp;
        res = 3'b000;
        bp = 4'hF;
        for (int k = 0; k < 4; k++) begin
            if (v[k] && (!res[2] || p[4*k +: 4] < bp)) begin
                res = {1'b1, 2'(k)};
                bp = p[4*k +: 4];
            end
        end
        return res;
    endfunction

    logic [1:0] active_r;
    logic ref_ok_r;
    wire [2:0] best = best_of(valid, prio_r);
    wire [1:0] man_code = ctrl_r.sel_from_reg ? ctrl_r.reg_sel
                                              : i_in_sel_pins;
    wire man_ok = valid[man_code] &&
                  !(ctrl_r.zero_delay && man_code == 2'b11);
    wire keep = ref_ok_r && valid[active_r];
    wire take_best = ctrl_r.revertive || !keep;
    wire [1:0] auto_sel = take_best ? best[1:0] : active_r;
    wire auto_ok = take_best ? best[2] : 1'b1;
    wire [1:0] sel_nxt = ctrl_r.auto_mode ? auto_sel : man_code;
    wire ok_nxt = ctrl_r.auto_mode ? auto_ok : man_ok;
    wire switched = ok_nxt && (!ref_ok_r || sel_nxt != active_r);

    // Active reference register.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            active_r <= 2'b00;
            ref_ok_r <= 1'b0;
        end else begin
            active_r <= sel_nxt;
            ref_ok_r <= ok_nxt;
        end
    end

    // ==========================================================
    // Lock-loss monitor
    // ==========================================================
    lock_st_e st_r, st_nxt;
    logic [15:0] tmr_r, tmr_nxt;
    logic ever_locked_r;
    // Separate thresholds give hysteresis between set and clear.
    wire lol_set = i_pd_freq_diff > lolcfg_r[15:0];
    wire clr_ok = i_pd_freq_diff < lolcfg_r[31:16];
    wire drop = !ok_nxt || switched;

    // Next state of the lock machine.
    always_comb begin
        st_nxt = st_r;
        tmr_nxt = tmr_r;
        case (st_r)
            ST_ACQ: begin
                if (!drop && clr_ok) begin
                    tmr_nxt = loltmr_r;
                    st_nxt = ST_CLR_WAIT;
                end
            end
            ST_CLR_WAIT: begin
                if (drop || !clr_ok) st_nxt = ST_ACQ;
                else if (tmr_r == 16'h0000) st_nxt = ST_LOCKED;
                else tmr_nxt = tmr_r - 16'h0001;
            end
            ST_LOCKED: begin
                if (drop || lol_set) st_nxt = ST_ACQ;
            end
            default: st_nxt = ST_ACQ;
        endcase
    end

    // Lock machine state.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_r <= ST_ACQ;
            tmr_r <= 16'h0000;
            ever_locked_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            if (st_r == ST_LOCKED) ever_locked_r <= 1'b1;
        end
    end

    // ==========================================================
    // Crystal loss, status and outputs
    // ==========================================================
    logic [15:0] xper_r;
    logic ref_los_r;
    logic [31:0] rdata_r;

    // Crystal period watchdog.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            xper_r <= 16'h0000;
            ref_los_r <= 1'b0;
        end else begin
            xper_r <= xtal_edge ? 16'h0000 : xper_r + 16'h0001;
            if (xtal_edge) ref_los_r <= 1'b0;
            else if (xper_r >= REF_LOS_LIMIT) ref_los_r <= 1'b1;
        end
    end

    // Live status assembly.
    assign live.signal_loss_flag = los_live;
    assign live.ref_los = ref_los_r;
    assign live.freq_out_of_range_flag = oof_live;
    assign live.lock_loss_flag = (st_r != ST_LOCKED);
    assign live.hold = !ref_ok_r && ever_locked_r;

    // Read mux; unmapped addresses read as zero.
    wire [31:0] rd_mux =
        (i_addr == OFF_CTRL) ? {19'h00000, ctrl_r} :
        (i_addr == OFF_INCFG) ? {20'h00000, incfg_r} :
        (i_addr == OFF_PRIO) ? {16'h0000, prio_r} :
        (i_addr == OFF_LOSCFG) ? {8'h00, loscfg_r} :
        (i_addr == OFF_OOFCFG) ? {16'h0000, oofcfg_r} :
        (i_addr == OFF_LOLCFG) ? lolcfg_r :
        (i_addr == OFF_LOLTMR) ? {16'h0000, loltmr_r} :
        (i_addr == OFF_LIVE) ? {18'h00000, active_r, 1'b0, live} :
        (i_addr == OFF_STICKY) ? {21'h000000, sticky_r} :
        (i_addr == OFF_MASK) ? {21'h000000, mask_r} : 32'h00000000;

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) rdata_r <= 32'h00000000;
        else rdata_r <= i_rd ? rd_mux : 32'h00000000;
    end

    assign o_rdata = rdata_r;
    assign o_active_sel = active_r;
    assign o_ref_valid = ref_ok_r;
    assign o_holdover = live.hold;
    assign o_freerun = !ref_ok_r && !ever_locked_r;
    assign o_hitless_en = ctrl_r.hitless;
    assign o_fastlock = ref_ok_r && live.lock_loss_flag;
    assign o_external_feedback_input = ctrl_r.zero_delay;
    assign o_outputs_enable = !(ref_los_r && !ctrl_r.shutdown_off);
    assign o_in_enable = incfg_r[3:0];
    assign o_in_differential = incfg_r[7:4];
    assign o_lock_loss_flag = live.lock_loss_flag;
    assign o_status_interrupt_pin = |(sticky_r & mask_r);

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    property p_sticky_hold;
        sticky_r[0] && !(wr_sticky && i_wdata[0]) |=> sticky_r[0];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold)
        else $error("sticky signal-loss bit dropped without a clear");

    property p_set_wins;
        live.lock_loss_flag && wr_sticky && i_wdata[9] |=> sticky_r[9];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear write beat a present lock-loss condition");

    property p_zd_never3;
        ctrl_r.zero_delay && ref_ok_r |-> active_r != 2'b11;
    endproperty
    a_zd_never3: assert property (p_zd_never3)
        else $error("feedback input chosen as reference");

    property p_no_ref;
        !ok_nxt |=> !o_ref_valid && (o_holdover || o_freerun);
    endproperty
    a_no_ref: assert property (p_no_ref)
        else $error("no valid input yet not in holdover or free-run");

    property p_revert;
        ctrl_r.auto_mode && ctrl_r.revertive && best[2]
            |=> o_ref_valid && active_r == $past(best[1:0]);
    endproperty
    a_revert: assert property (p_revert)
        else $error("revertive mode did not take the best input");

    property p_nonrev;
        ctrl_r.auto_mode && !ctrl_r.revertive && keep
            |=> $stable(active_r) && ref_ok_r;
    endproperty
    a_nonrev: assert property (p_nonrev)
        else $error("non-revertive mode left a valid active input");

    property p_lol_pin;
        o_lock_loss_flag == rd_mux[9] || i_addr != OFF_LIVE;
    endproperty
    a_lol_pin: assert property (p_lol_pin)
        else $error("lock-loss pin differs from live status");

    property p_lock_timer;
        st_r == ST_CLR_WAIT && tmr_r != 16'h0000 |=> st_r != ST_LOCKED;
    endproperty
    a_lock_timer: assert property (p_lock_timer)
        else $error("lock-loss cleared before its timer ran out");

    property p_xtal_off;
        ref_los_r && !ctrl_r.shutdown_off |-> !o_outputs_enable;
    endproperty
    a_xtal_off: assert property (p_xtal_off)
        else $error("outputs enabled during crystal loss");

    property p_int;
        (sticky_r & mask_r) == 11'h000 |-> !o_status_interrupt_pin;
    endproperty
    a_int: assert property (p_int)
        else $error("interrupt pin high with no masked-in status");

endmodule : input_select_fault_monitor
`default_nettype wire

// ===== ref_clock_sources.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Reference clock sources and crystal
// ==========================================================
module ref_clock_sources (
    // Clock and stop controls.
    input wire logic i_ref_clk,
    input wire logic [4:0] i_stop,
    // Source outputs.
    output logic [3:0] o_clk_in,
    output logic o_xtal_clk
);
    logic [2:0] div_r = 3'h0;

    // One shared divider keeps every source at the same nominal rate.
    always_ff @(posedge i_ref_clk) begin
        div_r <= div_r + 3'h1;
    end

    // A stopped source sits low, as a dead oscillator would.
    // Equal rates let any of them serve as the zero ppm reference.
    assign o_clk_in = div_r[2] ? ~i_stop[3:0] : 4'h0;
    assign o_xtal_clk = div_r[2] & ~i_stop[4];
endmodule : ref_clock_sources
`default_nettype wire

// ===== input_select_fault_monitor_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Self-checking bench
// ==========================================================
module input_select_fault_monitor_tb;
    import fault_monitor_pkg::*;
    logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [5:0] i_addr = 6'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, rv;
    logic [3:0] i_clk_in, o_in_enable, o_in_differential;
    logic [1:0] i_in_sel_pins = 2'h0, o_active_sel;
    logic [15:0] i_pd_freq_diff = 16'h0000;
    logic [4:0] stop = 5'h00;
    logic i_xtal_clk, o_ref_valid, o_holdover, o_freerun, o_hitless_en;
    logic o_fastlock, o_external_feedback_input, o_outputs_enable;
    logic o_lock_loss_flag, o_status_interrupt_pin;
    int error_cnt = 0, cmp_count = 0, k;

    always #20 i_ref_clk = ~i_ref_clk;

    input_select_fault_monitor #(.PRECISE_WIN(1000), .FAST_WIN(1000))
        input_select_fault_monitor_inst (.i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_clk_in(i_clk_in),
        .i_xtal_clk(i_xtal_clk), .i_in_sel_pins(i_in_sel_pins),
        .i_pd_freq_diff(i_pd_freq_diff), .o_active_sel(o_active_sel),
        .o_ref_valid(o_ref_valid), .o_holdover(o_holdover),
        .o_freerun(o_freerun), .o_hitless_en(o_hitless_en),
        .o_fastlock(o_fastlock),
        .o_external_feedback_input(o_external_feedback_input),
        .o_outputs_enable(o_outputs_enable), .o_in_enable(o_in_enable),
        .o_in_differential(o_in_differential),
        .o_lock_loss_flag(o_lock_loss_flag),
        .o_status_interrupt_pin(o_status_interrupt_pin));

    ref_clock_sources ref_clock_sources_inst (.i_ref_clk(i_ref_clk),
        .i_stop(stop), .o_clk_in(i_clk_in), .o_xtal_clk(i_xtal_clk));

    // Compare one value and count it.
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One-cycle write strobe.
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : wr

    // One-cycle read strobe; data stand only in the following cycle.
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    // Bounded wait for the selector to reach a given input.
    task automatic wsel(input logic [1:0] s);
        for (k = 0; k < 800 && o_active_sel !== s; k++) @(posedge i_ref_clk);
        #1 chk("active_sel", 32'(s), 32'(o_active_sel));
    endtask : wsel

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    // Watchdog sized well above the longest expected run.
    initial begin
        repeat (30000) @(posedge i_ref_clk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        #1 chk("freerun", 32'h1, 32'(o_freerun));
        chk("outputs_enable", 32'h1, 32'(o_outputs_enable));
        rd(OFF_CTRL, rv); chk("ctrl", 32'h1800, rv);
        rd(OFF_INCFG, rv); chk("incfg", 32'h0F0F, rv);
        rd(OFF_PRIO, rv); chk("prio", 32'h3210, rv);
        rd(6'h3C, rv); chk("unmapped", 32'h0, rv);
        $display("reset test done");
        for (int s = 3; s >= 0; s--) begin
            @(posedge i_ref_clk);
            i_in_sel_pins <= 2'(s);
            wsel(2'(s));
        end
        for (k = 0; k < 200 && o_lock_loss_flag !== 1'b0; k++)
            @(posedge i_ref_clk);
        #1 chk("lock_loss", 32'h0, 32'(o_lock_loss_flag));
        stop <= 5'h01;
        for (k = 0; k < 800 && o_ref_valid !== 1'b0; k++) @(posedge i_ref_clk);
        #1 chk("holdover", 32'h1, 32'(o_holdover));
        stop <= 5'h00;
        wr(OFF_CTRL, 32'h1803); wsel(2'h1);
        wr(OFF_CTRL, 32'h1827); repeat (4) @(posedge i_ref_clk);
        #1 chk("feedback", 32'h1, 32'(o_external_feedback_input));
        chk("ref_valid", 32'h0, 32'(o_ref_valid));
        wr(OFF_INCFG, 32'h0F5A); #1;
        chk("in_cfg", 32'h5A,
            {24'h0, o_in_differential, o_in_enable});
        wr(OFF_INCFG, 32'h0F0F);
        $display("manual test done");
        wr(OFF_CTRL, 32'h1818); wsel(2'h0);
        stop <= 5'h01; wsel(2'h1);
        rd(OFF_LIVE, rv); chk("live_los0", 32'h1, {31'h0, rv[0]});
        stop <= 5'h00; wsel(2'h0);
        for (k = 0; k < 4 && o_lock_loss_flag !== 1'b1; k++)
            @(posedge i_ref_clk);
        #1 chk("pull_in_lol", 32'h1, 32'(o_lock_loss_flag));
        chk("fastlock", 32'h1, 32'(o_fastlock));
        wr(OFF_CTRL, 32'h1808);
        stop <= 5'h01; wsel(2'h1);
        stop <= 5'h00; repeat (400) @(posedge i_ref_clk);
        #1 chk("keep_sel", 32'h1, 32'(o_active_sel));
        wr(OFF_CTRL, 32'h1818); wr(OFF_PRIO, 32'h0011); wsel(2'h2);
        wr(OFF_PRIO, 32'h3210); wsel(2'h0);
        $display("automatic test done");
        wr(OFF_MASK, 32'h001); #1;
        chk("irq", 32'h1, 32'(o_status_interrupt_pin));
        wr(OFF_STICKY, 32'h7FF); rd(OFF_STICKY, rv);
        chk("sticky_los0", 32'h0, {31'h0, rv[0]});
        chk("irq_clear", 32'h0, 32'(o_status_interrupt_pin));
        for (k = 0; k < 400 && o_lock_loss_flag !== 1'b0; k++)
            @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        i_pd_freq_diff <= 16'h0020; repeat (6) @(posedge i_ref_clk);
        #1 chk("lol_set", 32'h1, 32'(o_lock_loss_flag));
        @(posedge i_ref_clk);
        i_pd_freq_diff <= 16'h0000; repeat (9) @(posedge i_ref_clk);
        #1 chk("lol_delay", 32'h1, 32'(o_lock_loss_flag));
        for (k = 0; k < 40 && o_lock_loss_flag !== 1'b0; k++)
            @(posedge i_ref_clk);
        #1 chk("lol_clear", 32'h0, 32'(o_lock_loss_flag));
        $display("status test done");
        // Input 0 lost many edges in the first window, so its frequency
        // flag must rise at that window's end and fall after a clean one.
        rv = 32'h0;
        for (k = 0; k < 4500 && rv[5] !== 1'b1; k++) rd(OFF_LIVE, rv);
        chk("oof_set", 32'h1, {31'h0, rv[5]});
        wsel(2'h1);
        wr(OFF_CTRL, 32'h0018); rd(OFF_LIVE, rv);
        chk("oof_off", 32'h0, {31'h0, rv[5]});
        wr(OFF_CTRL, 32'h1818); rv = 32'hFFFFFFFF;
        for (k = 0; k < 4500 && rv[5] !== 1'b0; k++) rd(OFF_LIVE, rv);
        chk("oof_clear", 32'h0, {31'h0, rv[5]});
        wsel(2'h0);
        $display("frequency test done");
        stop <= 5'h10;
        for (k = 0; k < 300 && o_outputs_enable !== 1'b0; k++)
            @(posedge i_ref_clk);
        #1 chk("xtal_shutdown", 32'h0, 32'(o_outputs_enable));
        wr(OFF_CTRL, 32'h18D8); repeat (2) @(posedge i_ref_clk);
        #1 chk("shutdown_off", 32'h1, 32'(o_outputs_enable));
        chk("hitless", 32'h1, 32'(o_hitless_en));
        $display("crystal test done");
        end_of_test();
    end
endmodule : input_select_fault_monitor_tb
`default_nettype wire
